//--- rtl/fpse_defs.svh
// object indices, field layouts and timing counts for the fieldbus slave block
`ifndef FPSE_DEFS_SVH
`define FPSE_DEFS_SVH
`define FPSE_IDX_FAULT_CLASS  16'h1001
`define FPSE_IDX_RX_ASSIGN    16'h1C12
`define FPSE_IDX_TX_ASSIGN    16'h1C13
`define FPSE_IDX_FAULT_CODE   16'h603F
`define FPSE_IDX_RX_VARMAP    16'h1600
`define FPSE_IDX_TX_VARMAP    16'h1A00
`define FPSE_IDX_RX_FIX_LO    16'h1701
`define FPSE_IDX_RX_FIX_HI    16'h1705
`define FPSE_IDX_TX_FIX_LO    16'h1B01
`define FPSE_IDX_TX_FIX_HI    16'h1B04
`define FPSE_SUB_COUNT        8'h00
`define FPSE_SUB_FIRST        8'h01
`define FPSE_MAP_MAX          8'h0A
`define FPSE_ENT_IDX_HI       31
`define FPSE_ENT_IDX_LO       16
`define FPSE_ENT_SUB_HI       15
`define FPSE_ENT_SUB_LO       8
`define FPSE_ENT_LEN_HI       7
`define FPSE_ENT_LEN_LO       0
`define FPSE_LEN_8            8'h08
`define FPSE_LEN_16           8'h10
`define FPSE_LEN_32           8'h20
`define FPSE_CLS_COMMON       0
`define FPSE_CLS_CURRENT      1
`define FPSE_CLS_VOLTAGE      2
`define FPSE_CLS_TEMP         3
`define FPSE_CLS_COMM         4
`define FPSE_EMCY_BYTES       3'h6
`define FPSE_EMCY_RSVD_FIRST  3'h3
`define FPSE_RX_ASSIGN_RST    16'h1600
`define FPSE_TX_ASSIGN_RST    16'h1A00
`define FPSE_CLK_KHZ          20000
`define FPSE_BLINK_HALF_MS    168
`define FPSE_FLASH_HALF_MS    178
`endif

//--- rtl/fpse_fifo.sv
// byte fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module fpse_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW    = $clog2(DEPTH)
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    wire              full   = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire              empty  = (wr_q == rd_q);
    wire              do_wr  = in_valid && !full;
    wire              do_rd  = out_ready && !empty;

    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_q[AW-1:0]];

    always_ff @(posedge core_clk) begin
        if (do_wr) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(do_wr);
            rd_q <= rd_q + (AW+1)'(do_rd);
        end
    end
endmodule
`default_nettype wire

//--- rtl/fpse_pkg.sv
// types shared by the fieldbus slave block
package fpse_pkg;
    typedef enum logic [3:0] {
        FPSE_ESM_INIT   = 4'h1,
        FPSE_ESM_PREOP  = 4'h2,
        FPSE_ESM_SAFEOP = 4'h4,
        FPSE_ESM_OP     = 4'h8
    } fpse_esm_t;
    typedef enum logic [3:0] {
        FPSE_SVC_EMCY     = 4'h1,
        FPSE_SVC_SDO_REQ  = 4'h2,
        FPSE_SVC_SDO_RSP  = 4'h3,
        FPSE_SVC_TXPDO    = 4'h4,
        FPSE_SVC_RXPDO    = 4'h5,
        FPSE_SVC_RTR_TX   = 4'h6,
        FPSE_SVC_RTR_RX   = 4'h7,
        FPSE_SVC_SDO_INFO = 4'h8
    } fpse_svc_t;
    typedef enum logic [1:0] {
        FPSE_EM_IDLE = 2'b00,
        FPSE_EM_LOAD = 2'b01,
        FPSE_EM_SEND = 2'b11
    } fpse_em_state_t;
endpackage

//--- rtl/fpse_top.sv
// fieldbus slave: pdo assignment, mapping, sync, indicators, emergency
//
// What this block and the master do
// (RULE1) rx assignment sub 1 holds one rx map: variable or fixed 1..5.
// (RULE2) tx assignment sub 1 holds one tx map: variable or fixed 1..4.
// (RULE3) mapping sub 0 holds entry count; data length within four bytes per entry.
// (RULE4) mapping entry is index, sub-index, length in one 32-bit word.
// (RULE5) entry length is in bits: 08h, 10h or 20h only.
// (RULE6) only emergency, sdo request/response, tx and rx pdo services supported.
// (RULE7) in dc mode the sync cycle follows the sync0 event.
// (RULE8) master picks dc cycles as multiples of 4/base, at least 600 us.
// (RULE9) link indicator dark without link, lit with link.
// (RULE10) run indicator off in init, steady on in operational.
// (RULE11) run blinks 50% at 336 ms in pre-op, flashes 178 ms in safe-op.
// (RULE12) every alarm sends an emergency with fault code and fault class.
// (RULE13) emergency is six bytes: code, class, three reserved bytes.
// (RULE14) each alarm number maps to a fixed fault code.
// (RULE15) fault class bits: common, current, voltage, temperature, communication.
// (RULE16) current, voltage and temperature codes set class bits 1, 2, 3.
// (RULE17) comm codes FF37h, FF38h, FF39h and FF40h set bit 4; other codes set bit 0.
// (RULE18) reserved bytes are zero; code and class update before sending.
// (RULE19) out-of-range assignment or mapping refused; previous value kept.
`timescale 1ns/1ns
`default_nettype none
`include "fpse_defs.svh"
module fpse_top #(
    parameter int BLINK_HALF_CYC = `FPSE_BLINK_HALF_MS * `FPSE_CLK_KHZ,
    parameter int FLASH_HALF_CYC = `FPSE_FLASH_HALF_MS * `FPSE_CLK_KHZ
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // object dictionary access
    input  wire logic        od_wr,
    input  wire logic        od_rd,
    input  wire logic [15:0] od_index,
    input  wire logic [7:0]  od_subidx,
    input  wire logic [31:0] od_wdata,
    output logic      [31:0] od_rdata,
    output logic             od_ack,
    output logic             od_err,
    // mailbox service check
    input  wire logic        svc_valid,
    input  wire logic [3:0]  svc_type,
    output logic             svc_ok,
    // distributed clock
    input  wire logic        dc_mode,
    input  wire logic        sync0,
    output logic             sync_tick,
    output logic      [23:0] sync_period,
    // indicators
    input  wire logic        phy_link,
    input  wire logic [3:0]  esm_state,
    output logic             link_led,
    output logic             run_led,
    // alarms
    input  wire logic        alarm_valid,
    input  wire logic [5:0]  alarm_num,
    output logic             alarm_ready,
    // emergency byte stream
    output logic             emcy_valid,
    input  wire logic        emcy_ready,
    output logic      [7:0]  emcy_data,
    // active assignment
    output logic      [15:0] rx_assign,
    output logic      [15:0] tx_assign
);
    // ------------------------------------------------------------
    // alarm to fault code and fault class
    // ------------------------------------------------------------
    function automatic logic [15:0] alarm_code(input logic [5:0] n);
        case (n)
            6'd1:    alarm_code = 16'h2311;
            6'd2:    alarm_code = 16'h3210;
            6'd3:    alarm_code = 16'h3220;
            6'd4:    alarm_code = 16'h5210;
            6'd5:    alarm_code = 16'hFF05;
            6'd6:    alarm_code = 16'h3230;
            6'd7:    alarm_code = 16'h8400;
            6'd8:    alarm_code = 16'h2221;
            6'd9:    alarm_code = 16'h8611;
            6'd10:   alarm_code = 16'h7305;
            6'd11:   alarm_code = 16'hFF11;
            6'd12:   alarm_code = 16'h4210;
            6'd13:   alarm_code = 16'h3130;
            6'd14:   alarm_code = 16'hFF14;
            6'd16:   alarm_code = 16'hFF16;
            6'd17:   alarm_code = 16'hFF17;
            6'd18:   alarm_code = 16'hFF18;
            6'd19:   alarm_code = 16'hFF19;
            6'd20:   alarm_code = 16'hFF20;
            6'd23:   alarm_code = 16'h3331;
            6'd24:   alarm_code = 16'hFF24;
            6'd25:   alarm_code = 16'h4210;
            6'd26:   alarm_code = 16'hFF26;
            6'd27:   alarm_code = 16'hFF27;
            6'd28:   alarm_code = 16'h5530;
            6'd29:   alarm_code = 16'h2240;
            6'd30:   alarm_code = 16'h7121;
            6'd31:   alarm_code = 16'hFF31;
            6'd35:   alarm_code = 16'hFF35;
            6'd36:   alarm_code = 16'hFF36;
            6'd37:   alarm_code = 16'hFF37;
            6'd38:   alarm_code = 16'hFF38;
            6'd39:   alarm_code = 16'hFF39;
            6'd40:   alarm_code = 16'hFF40;
            default: alarm_code = 16'hFF00 | {10'h0, n};
        endcase
    endfunction

    function automatic logic [7:0] fault_class(input logic [15:0] c);
        fault_class = 8'h00;
        // (RULE16) current, voltage, temperature bits
        // (RULE17) comm bit 4, others bit 0
        case (c)
            16'h2311, 16'h3230, 16'h2221: fault_class[`FPSE_CLS_CURRENT] = 1'b1;
            16'h3130, 16'h3210, 16'h3220: fault_class[`FPSE_CLS_VOLTAGE] = 1'b1;
            16'h4210:                     fault_class[`FPSE_CLS_TEMP]    = 1'b1;
            16'hFF37, 16'hFF38, 16'hFF39, 16'hFF40: fault_class[`FPSE_CLS_COMM] = 1'b1;
            default:                      fault_class[`FPSE_CLS_COMMON]  = 1'b1;
        endcase
    endfunction

    // ------------------------------------------------------------
    // object access decode
    // ------------------------------------------------------------
    logic [31:0] rx_map_q [10];
    logic [31:0] tx_map_q [10];
    logic [7:0]  rx_cnt_q;
    logic [7:0]  tx_cnt_q;
    logic [15:0] rx_asg_q;
    logic [15:0] tx_asg_q;
    logic [15:0] fcode_q;
    logic [7:0]  fclass_q;
    logic [9:0]  rx_lenok;
    logic [9:0]  tx_lenok;

    wire         hit_rxa   = od_index == `FPSE_IDX_RX_ASSIGN;
    wire         hit_txa   = od_index == `FPSE_IDX_TX_ASSIGN;
    wire         hit_rxm   = od_index == `FPSE_IDX_RX_VARMAP;
    wire         hit_txm   = od_index == `FPSE_IDX_TX_VARMAP;
    wire         hit_fcl   = od_index == `FPSE_IDX_FAULT_CLASS;
    wire         hit_fco   = od_index == `FPSE_IDX_FAULT_CODE;
    wire         sub_cnt   = od_subidx == `FPSE_SUB_COUNT;
    wire         sub_ent   = od_subidx >= `FPSE_SUB_FIRST && od_subidx <= `FPSE_MAP_MAX;
    wire         sub_one   = od_subidx == `FPSE_SUB_FIRST;
    wire [3:0]   ent_i     = 4'(od_subidx - `FPSE_SUB_FIRST);
    wire [15:0]  wval      = od_wdata[15:0];
    wire [7:0]   wlen      = od_wdata[`FPSE_ENT_LEN_HI:`FPSE_ENT_LEN_LO];
    wire [7:0]   wcnt      = od_wdata[7:0];
    // (RULE1) rx map range
    wire         rx_asg_ok = wval == `FPSE_IDX_RX_VARMAP
                          || (wval >= `FPSE_IDX_RX_FIX_LO && wval <= `FPSE_IDX_RX_FIX_HI);
    // (RULE2) tx map range
    wire         tx_asg_ok = wval == `FPSE_IDX_TX_VARMAP
                          || (wval >= `FPSE_IDX_TX_FIX_LO && wval <= `FPSE_IDX_TX_FIX_HI);
    // (RULE5) legal bit lengths
    wire         len_ok    = wlen == `FPSE_LEN_8 || wlen == `FPSE_LEN_16 || wlen == `FPSE_LEN_32;
    // (RULE3) count in range, entries below it hold legal lengths
    wire [9:0]   cnt_need  = 10'((11'h1 << wcnt[3:0]) - 11'h1);
    wire         rx_cnt_ok = wcnt <= `FPSE_MAP_MAX && (rx_lenok & cnt_need) == cnt_need;
    wire         tx_cnt_ok = wcnt <= `FPSE_MAP_MAX && (tx_lenok & cnt_need) == cnt_need;

    // (RULE4) entry word layout checked by its length field
    for (genvar g = 0; g < 10; g++) begin : g_lenok
        assign rx_lenok[g] = rx_map_q[g][7:0] == `FPSE_LEN_8 || rx_map_q[g][7:0] == `FPSE_LEN_16
                          || rx_map_q[g][7:0] == `FPSE_LEN_32;
        assign tx_lenok[g] = tx_map_q[g][7:0] == `FPSE_LEN_8 || tx_map_q[g][7:0] == `FPSE_LEN_16
                          || tx_map_q[g][7:0] == `FPSE_LEN_32;
    end

    // (RULE19) refuse out-of-range writes, keep previous content
    wire wr_rxa = od_wr && hit_rxa && sub_one && rx_asg_ok;
    wire wr_txa = od_wr && hit_txa && sub_one && tx_asg_ok;
    wire wr_rxc = od_wr && hit_rxm && sub_cnt && rx_cnt_ok;
    wire wr_txc = od_wr && hit_txm && sub_cnt && tx_cnt_ok;
    wire wr_rxe = od_wr && hit_rxm && sub_ent && len_ok;
    wire wr_txe = od_wr && hit_txm && sub_ent && len_ok;
    wire wr_ok  = wr_rxa || wr_txa || wr_rxc || wr_txc || wr_rxe || wr_txe;
    wire rd_ok  = hit_fcl || hit_fco || ((hit_rxa || hit_txa) && (sub_cnt || sub_one))
               || ((hit_rxm || hit_txm) && (sub_cnt || sub_ent));
    wire [31:0] rd_val = hit_fcl ? {24'h0, fclass_q}
                       : hit_fco ? {16'h0, fcode_q}
                       : (hit_rxa && sub_one) ? {16'h0, rx_asg_q}
                       : (hit_txa && sub_one) ? {16'h0, tx_asg_q}
                       : (hit_rxa || hit_txa) ? 32'h0000_0001
                       : (hit_rxm && sub_cnt) ? {24'h0, rx_cnt_q}
                       : (hit_txm && sub_cnt) ? {24'h0, tx_cnt_q}
                       : (hit_rxm && sub_ent) ? rx_map_q[ent_i]
                       : (hit_txm && sub_ent) ? tx_map_q[ent_i]
                       : 32'h0000_0000;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_asg_q <= `FPSE_RX_ASSIGN_RST;
            tx_asg_q <= `FPSE_TX_ASSIGN_RST;
            rx_cnt_q <= 8'h00;
            tx_cnt_q <= 8'h00;
            od_ack   <= 1'b0;
            od_err   <= 1'b0;
            od_rdata <= 32'h0000_0000;
            for (int i = 0; i < 10; i++) begin
                rx_map_q[i] <= 32'h0000_0000;
                tx_map_q[i] <= 32'h0000_0000;
            end
        end else begin
            od_ack <= od_wr || od_rd;
            od_err <= (od_wr && !wr_ok) || (od_rd && !od_wr && !rd_ok);
            if (od_rd && !od_wr) begin
                od_rdata <= rd_val;
            end
            if (wr_rxa) begin
                rx_asg_q <= wval;
            end
            if (wr_txa) begin
                tx_asg_q <= wval;
            end
            if (wr_rxc) begin
                rx_cnt_q <= wcnt;
            end
            if (wr_txc) begin
                tx_cnt_q <= wcnt;
            end
            if (wr_rxe) begin
                rx_map_q[ent_i] <= od_wdata;
            end
            if (wr_txe) begin
                tx_map_q[ent_i] <= od_wdata;
            end
        end
    end

    assign rx_assign = rx_asg_q;
    assign tx_assign = tx_asg_q;

    // ------------------------------------------------------------
    // mailbox services
    // ------------------------------------------------------------
    // (RULE6) supported service set
    assign svc_ok = svc_valid && svc_type >= fpse_pkg::FPSE_SVC_EMCY
                 && svc_type <= fpse_pkg::FPSE_SVC_RXPDO;

    // ------------------------------------------------------------
    // sync0 cycle
    // ------------------------------------------------------------
    logic [23:0] sync_cnt_q;
    logic        sync_tick_q;
    logic [23:0] sync_per_q;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync_cnt_q  <= 24'h00_0000;
            sync_per_q  <= 24'h00_0000;
            sync_tick_q <= 1'b0;
        end else begin
            // (RULE7) cycle taken from sync0 in dc mode
            sync_tick_q <= dc_mode && sync0;
            if (dc_mode && sync0) begin
                sync_per_q <= sync_cnt_q + 24'h00_0001;
                sync_cnt_q <= 24'h00_0000;
            end else if (dc_mode && sync_cnt_q != 24'hFF_FFFF) begin
                sync_cnt_q <= sync_cnt_q + 24'h00_0001;
            end
        end
    end
    assign sync_tick   = sync_tick_q;
    assign sync_period = sync_per_q;

    // ------------------------------------------------------------
    // indicators
    // ------------------------------------------------------------
    logic [22:0] led_cnt_q;
    logic        run_q;
    logic        link_q;
    wire         st_pre  = esm_state == fpse_pkg::FPSE_ESM_PREOP;
    wire         st_safe = esm_state == fpse_pkg::FPSE_ESM_SAFEOP;
    wire [22:0]  half    = st_pre ? 23'(BLINK_HALF_CYC - 1) : 23'(FLASH_HALF_CYC - 1);
    wire         blinky  = st_pre || st_safe;
    wire         wrap    = led_cnt_q >= half;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            led_cnt_q <= 23'h00_0000;
            run_q     <= 1'b0;
            link_q    <= 1'b0;
        end else begin
            // (RULE9) link lamp follows phy
            link_q <= phy_link;
            // (RULE11) blink and flash timing
            led_cnt_q <= (!blinky || wrap) ? 23'h00_0000 : led_cnt_q + 23'h00_0001;
            if (blinky) begin
                run_q <= wrap ? !run_q : run_q;
            end else begin
                // (RULE10) steady off or on
                run_q <= esm_state == fpse_pkg::FPSE_ESM_OP;
            end
        end
    end
    assign link_led = link_q;
    assign run_led  = run_q;

    // ------------------------------------------------------------
    // emergency generation
    // ------------------------------------------------------------
    fpse_pkg::fpse_em_state_t em_q;
    logic [2:0]  byte_q;
    logic        push;
    logic        push_rdy;
    logic [7:0]  push_data;
    assign alarm_ready = em_q == fpse_pkg::FPSE_EM_IDLE;
    assign push        = em_q == fpse_pkg::FPSE_EM_SEND;
    // (RULE13) byte order of the message
    // (RULE18) reserved bytes zero
    assign push_data = byte_q == 3'h0 ? fcode_q[7:0]
                     : byte_q == 3'h1 ? fcode_q[15:8]
                     : byte_q == 3'h2 ? fclass_q
                     : 8'h00;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            em_q     <= fpse_pkg::FPSE_EM_IDLE;
            byte_q   <= 3'h0;
            fcode_q  <= 16'h0000;
            fclass_q <= 8'h00;
        end else begin
            case (em_q)
                fpse_pkg::FPSE_EM_IDLE: begin
                    // (RULE12) alarm starts an emergency
                    if (alarm_valid) begin
                        // (RULE14) fixed alarm code
                        fcode_q <= alarm_code(alarm_num);
                        em_q    <= fpse_pkg::FPSE_EM_LOAD;
                    end
                end
                fpse_pkg::FPSE_EM_LOAD: begin
                    // (RULE15) class from the stored code
                    fclass_q <= fault_class(fcode_q);
                    byte_q   <= 3'h0;
                    em_q     <= fpse_pkg::FPSE_EM_SEND;
                end
                fpse_pkg::FPSE_EM_SEND: begin
                    if (push_rdy) begin
                        byte_q <= byte_q + 3'h1;
                        if (byte_q == `FPSE_EMCY_BYTES - 3'h1) begin
                            em_q <= fpse_pkg::FPSE_EM_IDLE;
                        end
                    end
                end
                default: em_q <= fpse_pkg::FPSE_EM_IDLE;
            endcase
        end
    end

    fpse_fifo #(
        .WIDTH (8),
        .DEPTH (32)
    ) u_emcy_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (push),
        .in_ready  (push_rdy),
        .in_data   (push_data),
        .out_valid (emcy_valid),
        .out_ready (emcy_ready),
        .out_data  (emcy_data)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_link_follow: assert property (@(posedge core_clk) disable iff (!rst_n) // (RULE9)
        phy_link |=> link_led) else $error("link lamp not lit");
    a_run_init_off: assert property (@(posedge core_clk) disable iff (!rst_n) // (RULE10)
        esm_state == fpse_pkg::FPSE_ESM_INIT |=> !run_led) else $error("run lamp lit in init");
    a_run_blink_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // (RULE11)
        (st_pre && $past(st_pre) && led_cnt_q < 23'(BLINK_HALF_CYC - 1)) |=> $stable(run_led))
        else $error("run lamp toggled early");
    a_rx_asg_keep: assert property (@(posedge core_clk) disable iff (!rst_n) // (RULE19)
        (od_wr && hit_rxa && sub_one && !rx_asg_ok) |=> (od_err && $stable(rx_assign)))
        else $error("bad rx assignment taken");
    a_tx_asg_take: assert property (@(posedge core_clk) disable iff (!rst_n) // (RULE2)
        (od_wr && hit_txa && sub_one && tx_asg_ok) |=> (!od_err && tx_assign == $past(wval)))
        else $error("tx assignment not taken");
    a_map_len_bad: assert property (@(posedge core_clk) disable iff (!rst_n) // (RULE5)
        (od_wr && hit_rxm && sub_ent && !len_ok) |=> od_err) else $error("bad length accepted");
    a_svc_refuse: assert property (@(posedge core_clk) disable iff (!rst_n) // (RULE6)
        (svc_type == fpse_pkg::FPSE_SVC_SDO_INFO) |-> !svc_ok) else $error("sdo info accepted");
    a_sync_tick: assert property (@(posedge core_clk) disable iff (!rst_n) // (RULE7)
        (dc_mode && sync0) |=> sync_tick) else $error("sync0 tick missing");
    a_emcy_rsvd_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // (RULE18)
        (push && byte_q >= `FPSE_EMCY_RSVD_FIRST) |-> push_data == 8'h00)
        else $error("reserved byte not zero");
    a_emcy_start: assert property (@(posedge core_clk) disable iff (!rst_n) // (RULE12)
        (alarm_valid && alarm_ready) |=> ##1 (push && byte_q == 3'h0
            && push_data == fcode_q[7:0])) else $error("emergency not started");
    a_class_comm: assert property (@(posedge core_clk) disable iff (!rst_n) // (RULE17)
        (push && fcode_q inside {16'hFF37, 16'hFF38, 16'hFF39, 16'hFF40}) |-> fclass_q == 8'h10)
        else $error("comm class wrong");
endmodule
`default_nettype wire

//--- verif/fpse_master_model.sv
// master model: emergency byte sink and sync0 source
`timescale 1ns/1ns
`default_nettype none
module fpse_master_model #(
    parameter int SYNC_GAP = 20
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // emergency stream
    input  wire logic       emcy_valid,
    output logic            emcy_ready,
    input  wire logic [7:0] emcy_data,
    // sync event
    output logic            sync0
);
    logic [7:0] rx_q[$];
    int         cnt = 0;
    initial emcy_ready = 1'h0;
    initial sync0 = 1'h0;
    always @(posedge core_clk) begin
        cnt <= (cnt == SYNC_GAP - 1) ? 0 : cnt + 1;
        sync0 <= rst_n && (cnt == 0);
        emcy_ready <= cnt[1];
        if (emcy_valid && emcy_ready)
            rx_q.push_back(emcy_data);
    end
endmodule
`default_nettype wire

//--- verif/test_fpse_top.sv
// self-checking bench for the fieldbus slave block
`timescale 1ns/1ns
`default_nettype none
module test_fpse_top;
    logic        core_clk = 1'h0, rst_n = 1'h0, od_wr = 1'h0, od_rd = 1'h0, svc_valid = 1'h0;
    logic        dc_mode = 1'h0, phy_link = 1'h0, alarm_valid = 1'h0, od_ack, od_err, svc_ok;
    logic        sync_tick, link_led, run_led, alarm_ready, emcy_valid, emcy_ready, sync0;
    logic [15:0] od_index = 16'h0, rx_assign, tx_assign;
    logic [7:0]  od_subidx = 8'h0, emcy_data;
    logic [31:0] od_wdata = 32'h0, od_rdata;
    logic [3:0]  svc_type = 4'h0, esm_state = 4'h1;
    logic [5:0]  alarm_num = 6'h0;
    logic [23:0] sync_period;
    logic [5:0]  an [6] = '{6'h01, 6'h02, 6'h0C, 6'h25, 6'h04, 6'h0D};
    logic [15:0] ac [6] = '{16'h2311, 16'h3210, 16'h4210, 16'hFF37, 16'h5210, 16'h3130};
    logic [7:0]  ak [6] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h01, 8'h04};
    int          bad_count = 0, n_checks = 0, k, t;
    always #25 core_clk = ~core_clk;
    fpse_top #(.BLINK_HALF_CYC(8), .FLASH_HALF_CYC(10)) dut (.core_clk, .rst_n, .od_wr,
        .od_rd, .od_index, .od_subidx, .od_wdata, .od_rdata, .od_ack, .od_err, .svc_valid,
        .svc_type, .svc_ok, .dc_mode, .sync0, .sync_tick, .sync_period, .phy_link, .esm_state,
        .link_led, .run_led, .alarm_valid, .alarm_num, .alarm_ready, .emcy_valid, .emcy_ready,
        .emcy_data, .rx_assign, .tx_assign);
    fpse_master_model u_master (.core_clk, .rst_n, .emcy_valid, .emcy_ready, .emcy_data, .sync0);
    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic od(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] wd, input logic e);
        od_wr <= wr;
        od_rd <= !wr;
        od_index <= idx;
        od_subidx <= sub;
        od_wdata <= wd;
        tick();
        check("od_ack", od_ack, 1'h1);
        check("od_err", od_err, e);
        od_wr <= 1'h0;
        od_rd <= 1'h0;
        tick();
    endtask
    task automatic alarm(input logic [5:0] n, input logic [15:0] c, input logic [7:0] cl);
        alarm_valid <= 1'h1;
        alarm_num <= n;
        tick();
        check("alarm_ready", alarm_ready, 1'h0);
        alarm_valid <= 1'h0;
        for (t = 0; t < 300 && u_master.rx_q.size() < 6; t++) tick();
        if (t == 300) begin
            bad_count++;
            final_report();
        end
        for (int i = 0; i < 6; i++)
            check("emcy_byte", u_master.rx_q[i], i == 0 ? c[7:0] : i == 1 ? c[15:8] : i == 2 ? cl : 8'h0);
        u_master.rx_q.delete();
        od(1'h0, 16'h603F, 8'h00, 32'h0, 1'h0);
        check("fault_code", od_rdata, {16'h0, c});
        od(1'h0, 16'h1001, 8'h00, 32'h0, 1'h0);
        check("fault_class", od_rdata, {24'h0, cl});
    endtask
    task automatic leds(input logic [3:0] st, input int tog, input logic lvl);
        int   n;
        logic p;
        n = 0;
        esm_state <= st;
        repeat (3) tick();
        if (tog == 0) check("run_led", run_led, lvl);
        for (int i = 0; i < 80; i++) begin
            p = run_led;
            tick();
            n += (run_led !== p);
        end
        check("run_toggles", n, tog);
    endtask
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (2) tick();
        rst_n <= 1'h1;
        dc_mode <= 1'h1;
        tick();
        check("rx_rst", rx_assign, 32'h1600);
        check("link_off", link_led, 1'h0);
        od(1'h1, 16'h1C12, 8'h01, 32'h1705, 1'h0);
        od(1'h1, 16'h1C12, 8'h01, 32'h1706, 1'h1);
        check("rx_assign", rx_assign, 32'h1705);
        od(1'h1, 16'h1C13, 8'h01, 32'h1B04, 1'h0);
        od(1'h1, 16'h1C13, 8'h01, 32'h1B05, 1'h1);
        check("tx_assign", tx_assign, 32'h1B04);
        od(1'h1, 16'h1600, 8'h01, 32'h6040_0018, 1'h1);
        for (k = 0; k < 3; k++) od(1'h1, 16'h1600, 8'h01, {24'h6040_00, 8'h08 << k}, 1'h0);
        od(1'h0, 16'h1600, 8'h01, 32'h0, 1'h0);
        check("map_entry", od_rdata, 32'h6040_0020);
        od(1'h1, 16'h1600, 8'h00, 32'h2, 1'h1);
        od(1'h1, 16'h1600, 8'h00, 32'hB, 1'h1);
        od(1'h1, 16'h1600, 8'h00, 32'h1, 1'h0);
        od(1'h1, 16'h1001, 8'h00, 32'h1, 1'h1);
        od(1'h0, 16'h2000, 8'h00, 32'h0, 1'h1);
        check("unknown_rd", od_rdata, 32'h0);
        $display("object test done");
        for (k = 1; k < 9; k++) begin
            svc_valid <= 1'h1;
            svc_type <= k[3:0];
            tick();
            check("svc_ok", svc_ok, k < 6);
        end
        svc_valid <= 1'h0;
        for (k = 0; k < 6; k++) alarm(an[k], ac[k], ak[k]);
        $display("emergency test done");
        phy_link <= 1'h1;
        repeat (2) tick();
        check("link_on", link_led, 1'h1);
        leds(4'h1, 0, 1'h0);
        leds(4'h2, 10, 1'h0);
        leds(4'h4, 8, 1'h0);
        leds(4'h8, 0, 1'h1);
        $display("indicator test done");
        for (k = 0; k < 2; k++) begin
            for (t = 0; t < 40 && sync0 !== 1'h1; t++) tick();
            bad_count += (t == 40);
            tick();
            check("sync_tick", sync_tick, k == 0);
            check("sync_period", sync_period, 32'h14);
            dc_mode <= 1'h0;
        end
        $display("sync test done");
        final_report();
    end
endmodule
`default_nettype wire
